// File: cts_consts.vh
// Constants for the conditional trap and tagged subtract slice.
// Assumes inclusion by bare name from the design file only.
`ifndef CTS_CONSTS_VH
`define CTS_CONSTS_VH

// Instruction format
`define CTS_OP_ARITH     2'h2
`define CTS_OP3_TICC     6'h3a
`define CTS_OP3_TSUB     6'h21
`define CTS_OP3_TSUBTV   6'h23

// Condition codes
`define CTS_CND_NEVER    4'h0
`define CTS_CND_EQ       4'h1
`define CTS_CND_LE       4'h2
`define CTS_CND_LT       4'h3
`define CTS_CND_LEU      4'h4
`define CTS_CND_CS       4'h5
`define CTS_CND_NEG      4'h6
`define CTS_CND_VS       4'h7
`define CTS_CND_ALWAYS   4'h8
`define CTS_CND_NE       4'h9
`define CTS_CND_GT       4'ha
`define CTS_CND_GE       4'hb
`define CTS_CND_GTU      4'hc
`define CTS_CND_CC       4'hd
`define CTS_CND_POS      4'he
`define CTS_CND_VC       4'hf

// Software trap type base
`define CTS_TT_SOFT_BASE 8'h80

// Flag positions in the 4-bit flag field {n,z,v,c}
`define CTS_FLG_N        3
`define CTS_FLG_Z        2
`define CTS_FLG_V        1
`define CTS_FLG_C        0

// Register byte addresses
`define CTS_REG_CTRL     8'h00
`define CTS_REG_STAT     8'h04
`define CTS_REG_MASK     8'h08
`define CTS_REG_FLAGS    8'h0c
`define CTS_REG_TTYPE    8'h10

// Event bits in status and mask
`define CTS_EV_SOFT      0
`define CTS_EV_TAG       1

// Reset values
`define CTS_CTRL_RST     1'h1
`define CTS_MASK_RST     2'h0
`define CTS_FLAGS_RST    4'h0
`define CTS_TTYPE_RST    8'h00

`endif

// File: cts_cond_trap_tsub.v
// Conditional software trap and tagged subtract execution slice.
// Assumes operand values arrive from same-clock register file logic
// and that trap outputs are consumed by the core trap logic.
// Software registers sit behind a classic Wishbone slave port.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "cts_consts.vh"

module cts_cond_trap_tsub #(
  parameter ADR_W = 8
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Instruction issue
  input  wire             valid_i,
  input  wire [31:0]      inst_i,
  input  wire [31:0]      src1_i,
  input  wire [31:0]      src2_i,
  input  wire             hp_trap_i,
  // Flag writes from other flag-setting units
  input  wire             ext_flag_we_i,
  input  wire [3:0]       ext_flags_i,
  // Results
  output reg              done_o,
  output reg              rd_we_o,
  output reg  [4:0]       rd_addr_o,
  output reg  [31:0]      rd_data_o,
  output reg  [3:0]       icc_o,
  // Trap outputs
  output reg              soft_trap_o,
  output reg  [7:0]       trap_type_field_o,
  output reg              tag_trap_o,
  output reg              next_inst_o,
  output reg              irq_o,
  // Wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [ADR_W-1:0] wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o
);

  // Condition evaluation against {n,z,v,c}
  function cond_true;
    input [3:0] cond;
    input [3:0] f;
    reg n;
    reg z;
    reg v;
    reg c;
    begin
      n = f[`CTS_FLG_N];
      z = f[`CTS_FLG_Z];
      v = f[`CTS_FLG_V];
      c = f[`CTS_FLG_C];
      case (cond)
        `CTS_CND_NEVER:  cond_true = 1'b0;
        `CTS_CND_ALWAYS: cond_true = 1'b1;
        `CTS_CND_EQ:     cond_true = z;
        `CTS_CND_NE:     cond_true = ~z;
        `CTS_CND_LE:     cond_true = z | (n ^ v);
        `CTS_CND_LT:     cond_true = n ^ v;
        `CTS_CND_GT:     cond_true = ~(z | (n ^ v));
        `CTS_CND_GE:     cond_true = ~(n ^ v);
        `CTS_CND_LEU:    cond_true = c | z;
        `CTS_CND_CS:     cond_true = c;
        `CTS_CND_GTU:    cond_true = ~(c | z);
        `CTS_CND_CC:     cond_true = ~c;
        `CTS_CND_NEG:    cond_true = n;
        `CTS_CND_VS:     cond_true = v;
        `CTS_CND_POS:    cond_true = ~n;
        `CTS_CND_VC:     cond_true = ~v;
        default:         cond_true = 1'b0;
      endcase
    end
  endfunction

  // Sign extension of the 13-bit immediate
  function [31:0] sext13;
    input [12:0] imm;
    begin
      sext13 = {{19{imm[12]}}, imm};
    end
  endfunction

  // Signed overflow of a minus b giving d
  function sub_ovf;
    input [31:0] a;
    input [31:0] b;
    input [31:0] d;
    begin
      sub_ovf = (a[31] & ~b[31] & ~d[31]) |
                (~a[31] & b[31] & d[31]);
    end
  endfunction

  // Nonzero tag bits in either operand
  function tag_bits;
    input [31:0] a;
    input [31:0] b;
    begin
      tag_bits = (|a[1:0]) | (|b[1:0]);
    end
  endfunction

  // Flags {n,z,v,c} from a difference, overflow and borrow
  function [3:0] sub_flags;
    input [31:0] d;
    input        v;
    input        c;
    begin
      sub_flags[`CTS_FLG_N] = d[31];
      sub_flags[`CTS_FLG_Z] = (d == 32'h00000000);
      sub_flags[`CTS_FLG_V] = v;
      sub_flags[`CTS_FLG_C] = c;
    end
  endfunction

  // Register address match for a bus access
  function reg_hit;
    input [7:0] adr;
    input [7:0] reg_adr;
    begin
      reg_hit = (adr == reg_adr);
    end
  endfunction

  // Clear-on-write-one of sticky bits
  function [1:0] w1c;
    input [1:0] cur;
    input [1:0] wr;
    begin
      w1c = cur & ~wr;
    end
  endfunction

  // Software-visible state
  reg         enable;
  reg  [1:0]  status;
  reg  [1:0]  mask;
  reg  [3:0]  icc;

  // Instruction fields
  wire [1:0]  op_field         = inst_i[31:30];
  wire [5:0]  op3_field        = inst_i[24:19];
  wire [3:0]  cond_field       = inst_i[28:25];
  wire [4:0]  dest_field       = inst_i[29:25];
  wire        use_imm          = inst_i[13];
  wire [31:0] signed_immediate_operand = sext13(inst_i[12:0]);

  // Decode
  wire        is_arith  = valid_i & enable & (op_field == `CTS_OP_ARITH);
  wire        is_ticc   = is_arith & (op3_field == `CTS_OP3_TICC);
  wire        is_tsub   = is_arith & (op3_field == `CTS_OP3_TSUB);
  wire        is_tsubtv = is_arith & (op3_field == `CTS_OP3_TSUBTV);

  // Operand and arithmetic
  wire [31:0] op2  = use_imm ? signed_immediate_operand : src2_i;
  wire [32:0] diff = {1'b0, src1_i} - {1'b0, op2};
  wire [31:0] res  = diff[31:0];
  wire        borrow = diff[32];
  wire        sgn_ovf = sub_ovf(src1_i, op2, res);
  wire        tag_ovf = sgn_ovf | tag_bits(src1_i, op2);
  wire [31:0] sum  = src1_i + op2;

  // Flags seen by the trap test
  wire [3:0]  eff_flags = ext_flag_we_i ? ext_flags_i : icc;
  wire        cond_hit  = cond_true(cond_field, eff_flags);
  wire        take_trap = is_ticc & cond_hit & ~hp_trap_i;
  wire        tv_trap   = is_tsubtv & tag_ovf;
  wire        tv_commit = is_tsubtv & ~tag_ovf;

  // Bus decode
  wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge at which the master sees ack high
  wire        bus_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire [7:0]  bus_adr = wb_adr_i[7:0];
  wire        wr_ctrl  = bus_wr & reg_hit(bus_adr, `CTS_REG_CTRL);
  wire        wr_stat  = bus_wr & reg_hit(bus_adr, `CTS_REG_STAT);
  wire        wr_mask  = bus_wr & reg_hit(bus_adr, `CTS_REG_MASK);
  wire        wr_flags = bus_wr & reg_hit(bus_adr, `CTS_REG_FLAGS);

  // Next flag value
  reg  [3:0]  next_icc;
  always @* begin
    next_icc = icc;
    if (wr_flags) begin
      next_icc = wb_dat_i[3:0];
    end
    if (ext_flag_we_i) begin
      next_icc = ext_flags_i;
    end
    if (is_tsub) begin
      next_icc = sub_flags(res, tag_ovf, borrow);
    end else if (tv_commit) begin
      next_icc = sub_flags(res, 1'b0, borrow);
    end
  end

  // Next status; a new event wins over a clear
  reg  [1:0]  next_status;
  always @* begin
    next_status = status;
    if (wr_stat) begin
      next_status = w1c(status, wb_dat_i[1:0]);
    end
    if (take_trap) begin
      next_status[`CTS_EV_SOFT] = 1'b1;
    end
    if (tv_trap) begin
      next_status[`CTS_EV_TAG] = 1'b1;
    end
  end

  // Read mux
  reg  [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (bus_adr)
      `CTS_REG_CTRL:  next_rdata[0]   = enable;
      `CTS_REG_STAT:  next_rdata[1:0] = status;
      `CTS_REG_MASK:  next_rdata[1:0] = mask;
      `CTS_REG_FLAGS: next_rdata[3:0] = icc;
      `CTS_REG_TTYPE: next_rdata[7:0] = trap_type_field_o;
      default:        next_rdata      = 32'h00000000;
    endcase
  end

  // Control enable
  always @(posedge clk_i) begin
    if (rst_i) begin
      enable <= `CTS_CTRL_RST;
    end else if (wr_ctrl) begin
      enable <= wb_dat_i[0];
    end
  end

  // Interrupt mask
  always @(posedge clk_i) begin
    if (rst_i) begin
      mask <= `CTS_MASK_RST;
    end else if (wr_mask) begin
      mask <= wb_dat_i[1:0];
    end
  end

  // Sticky status and flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      status <= 2'h0;
      icc    <= `CTS_FLAGS_RST;
    end else begin
      status <= next_status;
      icc    <= next_icc;
    end
  end

  // Level interrupt from unmasked status
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & mask);
    end
  end

  // Bus answer; ack drops the cycle after it is given
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_rdata : 32'h00000000;
    end
  end

  // Trap type for a taken soft trap; held otherwise
  reg  [7:0]  next_trap_type;
  always @* begin
    next_trap_type = trap_type_field_o;
    if (take_trap) begin
      next_trap_type = `CTS_TT_SOFT_BASE + {1'b0, sum[6:0]};
    end
  end

  // Execution results
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o    <= 1'b0;
      rd_we_o   <= 1'b0;
      rd_addr_o <= 5'h00;
      rd_data_o <= 32'h00000000;
      icc_o     <= `CTS_FLAGS_RST;
    end else begin
      done_o    <= is_ticc | is_tsub | is_tsubtv;
      rd_we_o   <= is_tsub | tv_commit;
      rd_addr_o <= dest_field;
      rd_data_o <= res;
      icc_o     <= next_icc;
    end
  end

  // Trap pulses
  always @(posedge clk_i) begin
    if (rst_i) begin
      soft_trap_o <= 1'b0;
      tag_trap_o  <= 1'b0;
      next_inst_o <= 1'b0;
    end else begin
      soft_trap_o <= take_trap;
      tag_trap_o  <= tv_trap;
      next_inst_o <= is_ticc & ~cond_hit;
    end
  end

  // Type of the last taken soft trap
  always @(posedge clk_i) begin
    if (rst_i) begin
      trap_type_field_o <= `CTS_TTYPE_RST;
    end else begin
      trap_type_field_o <= next_trap_type;
    end
  end

endmodule

// File: cts_cond_trap_tsub_properties.sv
// Checker for the trap and tagged subtract slice.
// Sees only top-level ports; bound to the design below.
`timescale 1ns/100ps
module cts_cond_trap_tsub_properties (
  input wire        clk_i, rst_i, valid_i, hp_trap_i,
  input wire [31:0] inst_i, src1_i, src2_i, rd_data_o,
  input wire        done_o, rd_we_o, soft_trap_o, tag_trap_o,
  input wire [3:0]  icc_o,
  input wire [7:0]  trap_type_field_o,
  input wire        wb_cyc_i, wb_stb_i, wb_ack_o, irq_o
);
  wire [31:0] op2 = inst_i[13] ? {{19{inst_i[12]}}, inst_i[12:0]} : src2_i;
  wire [31:0] diff = src1_i - op2;
  wire [6:0]  sum7 = src1_i[6:0] + op2[6:0];
  wire [5:0]  op3 = inst_i[24:19];
  wire [3:0]  cnd = inst_i[28:25];
  wire        arith = valid_i && inst_i[31:30] == 2'h2;
  wire        tagin = |{src1_i[1:0], op2[1:0]};
  wire        req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  decode_gate_a: assert property (done_o |-> $past(arith)) else $error("done without instr");
  never_cond_a: assert property (soft_trap_o |-> $past(cnd) != 4'h0) else $error("never trapped");
  trap_prio_a: assert property (soft_trap_o |-> done_o && !$past(hp_trap_i)) else $error("prio");
  trap_type_a: assert property (soft_trap_o |-> trap_type_field_o == {1'b1, $past(sum7)}) else $error("type");
  tsub_result_a: assert property (done_o && $past(op3) == 6'h21 |-> rd_we_o && !tag_trap_o &&
    rd_data_o == $past(diff)) else $error("tsub result");
  tag_source_a: assert property (done_o && $past(op3) == 6'h23 && $past(tagin) |-> tag_trap_o)
    else $error("tag missed");
  tag_hold_a: assert property (tag_trap_o |-> !rd_we_o && $stable(icc_o)) else $error("tag hold");
  tsubtv_clear_a: assert property (done_o && $past(op3) == 6'h23 && !tag_trap_o |-> rd_we_o && !icc_o[1])
    else $error("v not clear");
  ack_pulse_a: assert property (wb_ack_o |-> $past(req) ##1 !wb_ack_o) else $error("ack");
  cover property (soft_trap_o);
  cover property (tag_trap_o);
  cover property (irq_o);
endmodule
bind cts_cond_trap_tsub cts_cond_trap_tsub_properties i_prop (.*);

// File: test_cond_trap_tsub.sv
// Bench for the trap and tagged subtract slice.
// Drives every port at rising edges; Wishbone master inline.
`timescale 1ns/100ps
module test_cond_trap_tsub;
  reg         clk_i = 0, rst_i = 1, valid_i = 0, hp_trap_i = 0, ext_flag_we_i = 0;
  reg  [31:0] inst_i = 0, src1_i = 0, src2_i = 0, wb_dat_i = 0, a, b, r, rdv;
  reg  [3:0]  ext_flags_i = 0, wb_sel_i = 4'hf, fl, o;
  reg         wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg  [7:0]  wb_adr_i = 0;
  wire        done_o, rd_we_o, soft_trap_o, tag_trap_o, next_inst_o, irq_o, wb_ack_o;
  wire [4:0]  rd_addr_o;
  wire [31:0] rd_data_o, wb_dat_o;
  wire [3:0]  icc_o;
  wire [7:0]  trap_type_field_o;
  integer     n_mismatch = 0, samples_checked = 0, f, c, k;
  localparam [319:0] PR = {64'h8_00000008, 64'h80000000_00000004, 64'h1_00000004, 64'h4_00000008, 64'h8_00000004};
  always #2 clk_i = ~clk_i;
  cts_cond_trap_tsub i_dut (.*);
  task chk(input [31:0] s, e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task wb(input w, input [7:0] ad, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      k = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge clk_i);
      end
      rdv = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      if (k == 20) n_mismatch = n_mismatch + 1;
    end
  endtask
  // e = {higher trap pending, flag write, flags}
  task ex(input [31:0] in, s1, s2, input [5:0] e);
    begin
      @(posedge clk_i);
      valid_i <= 1;
      inst_i <= in;
      src1_i <= s1;
      src2_i <= s2;
      {hp_trap_i, ext_flag_we_i, ext_flags_i} <= e;
      @(posedge clk_i);
      valid_i <= 0;
      hp_trap_i <= 0;
      ext_flag_we_i <= 0;
      #1;
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge clk_i);
      #1;
    end
  endtask
  function ok(input [3:0] c, f);
    reg t;
    begin
      case (c[2:0])
        0: t = 0;
        1: t = f[2];
        2: t = f[2] | (f[3] ^ f[1]);
        3: t = f[3] ^ f[1];
        4: t = f[0] | f[2];
        5: t = f[0];
        6: t = f[3];
        default: t = f[1];
      endcase
      ok = t ^ c[3];
    end
  endfunction
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0);
    chk(rdv, 1);
    chk({icc_o, trap_type_field_o}, 0);
    for (f = 0; f < 16; f = f + 1) begin
      wb(1, 8'h0c, f);
      for (c = 0; c < 16; c = c + 1) begin
        a = f * 32'h1001;
        b = c * 32'h35;
        r = a + b;
        ex({2'h2, c[0], c[3:0], 6'h3a, 19'h0}, a, b, 0);
        chk(soft_trap_o, ok(c, f));
        chk(next_inst_o, !ok(c, f));
        if (ok(c, f)) chk(trap_type_field_o, {1'b1, r[6:0]});
      end
    end
    ex({2'h2, 5'h08, 6'h3a, 5'h0, 1'b1, 13'h1fff}, 5, 0, 6'h20);
    chk({done_o, soft_trap_o, next_inst_o}, 4);
    ex({2'h2, 5'h08, 6'h3a, 5'h0, 1'b1, 13'h1fff}, 5, 0, 0);
    chk(trap_type_field_o, 8'h84);
    ex({2'h2, 5'h09, 6'h3a, 19'h0}, 0, 0, 6'h10);
    chk(soft_trap_o, 1);
    ex({2'h3, 5'h10, 6'h3a, 19'h0}, 0, 0, 0);
    chk(done_o, 0);
    for (k = 0; k < 10; k = k + 1) begin
      {a, b} = PR[(k % 5) * 64 +: 64];
      r = a - b;
      fl = {r[31], r == 0, (a[31] ^ b[31]) & (a[31] ^ r[31]) | (|a[1:0]) | (|b[1:0]), a < b};
      o = icc_o;
      ex({2'h2, 5'h09, k < 5 ? 6'h21 : 6'h23, 5'h1, 14'h0}, a, b, 0);
      chk(soft_trap_o, 0);
      if (k < 5 || !fl[1]) begin
        chk({rd_we_o, rd_addr_o}, 6'h29);
        chk(rd_data_o, r);
        chk(icc_o, k < 5 ? fl : fl & 4'hd);
      end else
        chk({tag_trap_o, rd_we_o, icc_o}, {2'h2, o});
    end
    ex({2'h2, 5'h09, 6'h21, 5'h1, 1'b1, 13'h1ffc}, 8, 5, 0);
    chk({rd_data_o, icc_o}, {32'hc, 4'h1});
    wb(0, 8'h04, 0);
    chk(rdv, 3);
    wb(1, 8'h08, 2);
    settle;
    chk(irq_o, 1);
    wb(1, 8'h04, 2);
    settle;
    chk(irq_o, 0);
    wb(0, 8'h04, 0);
    chk(rdv, 1);
    wb(1, 8'h00, 0);
    ex({2'h2, 5'h10, 6'h3a, 19'h0}, 0, 0, 0);
    chk(done_o, 0);
    wb(0, 8'h20, 0);
    chk(rdv, 0);
    wb(0, 8'h10, 0);
    chk(rdv, 8'h80);
    report_and_stop;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
endmodule
